// ==== hw/bus_program_seq.sv ====
`default_nettype none
// Master bus program sequencer: connect, data, diagnostics, token.
module bus_program_seq
   import bus_program_pkg::*;
(
   // Clock, enable and reset.
   input  wire logic                                 clk,
   input  wire logic                                 rst_n,
   input  wire logic                                 ce,
   // Configuration from the host side, same clock.
   input  wire logic                                 multi_master,
   input  wire logic [bus_program_pkg::NUM_SLAVES-1:0] slave_cfg,
   input  wire logic [bus_program_pkg::NUM_SLAVES-1:0] out_data_flat_en,
   input  wire logic [bus_program_pkg::DATA_W-1:0]   out_data,
   // Link side, pins from outside the clock domain.
   input  wire logic                                 token_in,
   input  wire bus_program_pkg::answer_s             answer,
   input  wire logic [bus_program_pkg::NUM_SLAVES-1:0] diag_changed,
   output bus_program_pkg::request_s                 request,
   output logic                                      token_out,
   // Results to the host side.
   output logic [bus_program_pkg::NUM_SLAVES-1:0]    slave_ok,
   output logic                                      in_valid,
   input  wire logic                                 in_ready,
   output logic [bus_program_pkg::DATA_W-1:0]        in_data,
   output logic                                      steady
);
   import bus_program_pkg::*;

   // Two-stage synchronisers for link inputs.
   logic                  tok_s1_r, tok_s2_r;
   answer_s               ans_s1_r, ans_s2_r;
   logic [NUM_SLAVES-1:0] dg_s1_r, dg_s2_r;

   phase_e                phase_r;        // Current program part.
   logic [IDX_W-1:0]      idx_r;          // Slave being served.
   logic                  wait_r;         // Request outstanding.
   logic [NUM_SLAVES-1:0] ok_r;           // Addressable slaves.
   logic                  error_r;        // Reconnect due.
   logic                  steady_r;       // Power-up pass finished.
   request_s              req_r;
   logic                  tok_out_r;
   logic                  fvalid;
   logic                  fready;
   logic                  fo_valid;
   logic [DATA_W-1:0]     fo_data;
   logic                  connect_due;
   logic                  diag_due;
   logic                  link_free;      // No request outstanding, no answer draining.
   logic                  ans_take;       // Fresh answer to the outstanding request.
   logic                  in_valid_hold;  // Output word waits for the consumer.
   logic                  in_valid_r;     // Output word valid.
   logic [DATA_W-1:0]     in_data_r;      // Output word.

   // Synchronise everything arriving from the bus; only stage two is read.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tok_s1_r <= 1'b0;
         tok_s2_r <= 1'b0;
         ans_s1_r <= '0;
         ans_s2_r <= '0;
         dg_s1_r  <= '0;
         dg_s2_r  <= '0;
      end
      else if (ce)
      begin
         tok_s1_r <= token_in;
         tok_s2_r <= tok_s1_r;
         ans_s1_r <= answer;
         ans_s2_r <= ans_s1_r;
         dg_s1_r  <= diag_changed;
         dg_s2_r  <= dg_s1_r;
      end
   end

   // Reconnect when an error is pending or a configured slave is missing.
   assign connect_due = !steady_r || error_r || ((slave_cfg & ~ok_r) != '0);
   // Diagnostics only if some addressable slave reports a change.
   assign diag_due    = (dg_s2_r & ok_r) != '0;
   // A new request waits until the last answer has left the synchroniser,
   // otherwise that held answer would be taken again for the next slave.
   assign link_free   = !wait_r && !ans_s2_r.valid;
   assign ans_take    = wait_r && ans_s2_r.valid;
   assign fvalid      = req_r.valid && (req_r.kind == TG_DATA) && ans_s2_r.valid && ans_s2_r.ok;

   // Next slave index helper.
   function automatic logic [IDX_W-1:0] next_idx(input logic [IDX_W-1:0] i);
      next_idx = i + IDX_STEP;
   endfunction : next_idx

   // Program sequencer: walks parts in fixed order, one slave at a time.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase_r   <= PH_IDLE;
         idx_r     <= IDX_FIRST;
         wait_r    <= 1'b0;
         ok_r      <= '0;
         error_r   <= 1'b0;
         steady_r  <= 1'b0;
         req_r     <= '0;
         tok_out_r <= 1'b0;
      end
      else if (ce)
      begin
         tok_out_r <= 1'b0;
         case (phase_r)
            // Start the pass once the bus may be used.
            PH_IDLE:
            begin
               if (!multi_master || tok_s2_r)
               begin
                  idx_r   <= IDX_FIRST;
                  phase_r <= connect_due ? PH_CONNECT : PH_DATA;
                  error_r <= 1'b0;
               end
            end
            // Probe each configured slave (once steady, only those not addressable) and record the answer.
            PH_CONNECT:
            begin
               if (link_free)
               begin
                  if (slave_cfg[idx_r] && (!steady_r || !ok_r[idx_r]))
                  begin
                     req_r  <= '{valid: 1'b1, kind: TG_PROBE, slave: idx_r, data: '0};
                     wait_r <= 1'b1;
                  end
                  else if (idx_r == IDX_LAST)
                  begin
                     idx_r   <= IDX_FIRST;
                     phase_r <= PH_DATA;
                  end
                  else
                  begin
                     idx_r <= next_idx(idx_r);
                  end
               end
               else if (ans_take)
               begin
                  ok_r[idx_r] <= ans_s2_r.ok;
                  req_r.valid <= 1'b0;
                  wait_r      <= 1'b0;
                  if (idx_r == IDX_LAST)
                  begin
                     idx_r   <= IDX_FIRST;
                     phase_r <= PH_DATA;
                  end
                  else
                  begin
                     idx_r <= next_idx(idx_r);
                  end
               end
            end
            // Exchange data with addressable slaves only.
            PH_DATA:
            begin
               if (link_free)
               begin
                  if (ok_r[idx_r] && out_data_flat_en[idx_r] && fready)
                  begin
                     req_r  <= '{valid: 1'b1, kind: TG_DATA, slave: idx_r, data: out_data};
                     wait_r <= 1'b1;
                  end
                  else if (ok_r[idx_r] && out_data_flat_en[idx_r])
                  begin
                     phase_r <= PH_DATA;  // Stalled by a full input FIFO.
                  end
                  else if (idx_r == IDX_LAST)
                  begin
                     idx_r   <= IDX_FIRST;
                     phase_r <= diag_due ? PH_DIAG : PH_TOKEN;
                  end
                  else
                  begin
                     idx_r <= next_idx(idx_r);
                  end
               end
               else if (ans_take)
               begin
                  req_r.valid <= 1'b0;
                  wait_r      <= 1'b0;
                  if (!ans_s2_r.ok)
                  begin
                     ok_r[idx_r] <= 1'b0;
                     error_r     <= 1'b1;
                  end
                  if (idx_r == IDX_LAST)
                  begin
                     idx_r   <= IDX_FIRST;
                     phase_r <= diag_due ? PH_DIAG : PH_TOKEN;
                  end
                  else
                  begin
                     idx_r <= next_idx(idx_r);
                  end
               end
            end
            // Collect diagnostics from slaves that report a change.
            PH_DIAG:
            begin
               if (link_free)
               begin
                  if (dg_s2_r[idx_r] && ok_r[idx_r])
                  begin
                     req_r  <= '{valid: 1'b1, kind: TG_DIAG, slave: idx_r, data: '0};
                     wait_r <= 1'b1;
                  end
                  else if (idx_r == IDX_LAST)
                  begin
                     phase_r <= PH_TOKEN;
                  end
                  else
                  begin
                     idx_r <= next_idx(idx_r);
                  end
               end
               else if (ans_take)
               begin
                  req_r.valid <= 1'b0;
                  wait_r      <= 1'b0;
                  if (idx_r == IDX_LAST)
                  begin
                     phase_r <= PH_TOKEN;
                  end
                  else
                  begin
                     idx_r <= next_idx(idx_r);
                  end
               end
            end
            // Hand the token on, or loop straight back when alone.
            PH_TOKEN:
            begin
               steady_r <= 1'b1;
               if (multi_master)
               begin
                  tok_out_r <= 1'b1;
                  phase_r   <= PH_WAIT_TOKEN;
               end
               else
               begin
                  phase_r <= PH_IDLE;
               end
            end
            // Wait for our token grant to drop before waiting for the next.
            PH_WAIT_TOKEN:
            begin
               if (!tok_s2_r)
               begin
                  phase_r <= PH_IDLE;
               end
            end
            default:
            begin
               phase_r <= PH_IDLE;
            end
         endcase
      end
   end

   // Input words are buffered; a full FIFO stalls the data cycle.
   data_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .in_valid  (fvalid && wait_r),
      .in_ready  (fready),
      .in_data   (ans_s2_r.data),
      .out_valid (fo_valid),
      .out_ready (in_ready && !in_valid_hold),
      .out_data  (fo_data)
   );

   // Output register stage holds a word the consumer has not yet taken.
   assign in_valid_hold = in_valid_r && !in_ready;

   // Drained words pass a flop so outputs stay registered.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         in_valid_r <= 1'b0;
         in_data_r  <= '0;
      end
      else if (ce && !in_valid_hold)
      begin
         in_valid_r <= fo_valid && in_ready;
         in_data_r  <= fo_data;
      end
   end

   assign request   = req_r;
   assign token_out = tok_out_r;
   assign slave_ok  = ok_r;
   assign steady    = steady_r;
   assign in_valid  = in_valid_r;
   assign in_data   = in_data_r;

   // No request while another master owns the bus.
   a_token_guard: assert property (@(posedge clk) disable iff (!rst_n)
      (multi_master && phase_r == PH_WAIT_TOKEN) |-> !req_r.valid)
      else $error("request issued without token");
   // Data only to addressable slaves.
   a_data_target: assert property (@(posedge clk) disable iff (!rst_n)
      (req_r.valid && req_r.kind == TG_DATA) |-> ok_r[req_r.slave])
      else $error("data to unaddressable slave");
   // Token pulse only after the pass.
   a_token_pass: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(tok_out_r) |-> $past(phase_r) == PH_TOKEN && multi_master)
      else $error("token passed out of order");
   // Order of parts.
   a_part_order: assert property (@(posedge clk) disable iff (!rst_n)
      (phase_r == PH_DIAG) |-> $past(phase_r) inside {PH_DATA, PH_DIAG})
      else $error("diagnostics out of order");
   // Power-up begins with connecting.
   a_powerup_conn: assert property (@(posedge clk) disable iff (!rst_n)
      (!steady_r && phase_r == PH_DATA && $past(phase_r) == PH_IDLE) |-> 1'b0)
      else $error("power-up skipped connecting");
   // Steady state skips connecting without cause.
   a_steady_skip: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(phase_r) == PH_IDLE && phase_r == PH_CONNECT && $past(steady_r))
      |-> $past(connect_due))
      else $error("needless reconnect");
   // Diagnostics only when due.
   a_diag_due: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(phase_r) == PH_DATA && phase_r == PH_DIAG) |-> $past(diag_due))
      else $error("diagnostics without change");
   // Failed probe clears availability.
   a_fail_clear: assert property (@(posedge clk) disable iff (!rst_n)
      (phase_r == PH_CONNECT && wait_r && ans_s2_r.valid && !ans_s2_r.ok)
      |=> !ok_r[$past(idx_r)])
      else $error("failed slave kept");
endmodule : bus_program_seq
`default_nettype wire

// ==== pkg/bus_program_pkg.sv ====
`default_nettype none
package bus_program_pkg;
   // Number of slave stations the sequencer walks.
   localparam int unsigned NUM_SLAVES = 4;
   // Width of one data word carried to and from a slave.
   localparam int unsigned DATA_W = 8;
   // Depth of the input data FIFO.
   localparam int unsigned FIFO_DEPTH = 16;
   // Width of a slave index.
   localparam int unsigned IDX_W = 2;
   // First slave index and its step.
   localparam logic [IDX_W-1:0] IDX_FIRST = 2'h0;
   localparam logic [IDX_W-1:0] IDX_STEP  = 2'h1;
   localparam logic [IDX_W-1:0] IDX_LAST  = 2'h3;

   // Program parts, walked in a fixed order.
   typedef enum logic [2:0] {
      PH_IDLE,
      PH_CONNECT,
      PH_DATA,
      PH_DIAG,
      PH_TOKEN,
      PH_WAIT_TOKEN
   } phase_e;

   // Kind of telegram placed on the bus.
   typedef enum logic [1:0] {
      TG_PROBE,
      TG_DATA,
      TG_DIAG
   } telegram_e;

   // Request issued to a slave.
   typedef struct packed {
      logic             valid;
      telegram_e        kind;
      logic [IDX_W-1:0] slave;
      logic [DATA_W-1:0] data;
   } request_s;

   // Answer returned by the slave side.
   typedef struct packed {
      logic             valid;
      logic             ok;
      logic [DATA_W-1:0] data;
   } answer_s;
endpackage : bus_program_pkg
`default_nettype wire

// ==== hw/data_fifo.sv ====
`default_nettype none
// Synchronous FIFO with valid and ready on both sides.
module data_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   // Clock, enable and reset.
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   // Fill side.
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side.
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];  // Storage words.
   logic [AW-1:0]    wr_r;           // Write index.
   logic [AW-1:0]    rd_r;           // Read index.
   logic [AW:0]      cnt_r;          // Occupancy.
   logic             push;
   logic             pop;

   // Ready and valid are honest: full stops filling, empty stops draining.
   assign in_ready  = (cnt_r < (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rd_r];
   assign push      = in_valid && in_ready && ce;
   assign pop       = out_valid && out_ready && ce;

   // Storage write.
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_r[wr_r] <= in_data;
      end
   end

   // Index and occupancy bookkeeping.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
         end
         if (pop)
         begin
            rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : data_fifo
`default_nettype wire

// ==== verif/slave_station_model.sv ====
`default_nettype none
// Behavioural slave stations: one answer per request, held until the request drops.
module slave_station_model
   import bus_program_pkg::*;
(
   // Clock and reset.
   input  wire logic                                   clk,
   input  wire logic                                   rst_n,
   // Bus side facing the sequencer.
   input  wire bus_program_pkg::request_s              request,
   output bus_program_pkg::answer_s                    answer,
   output logic [bus_program_pkg::NUM_SLAVES-1:0]      diag_changed,
   // Scenario controls from the bench.
   input  wire logic [bus_program_pkg::NUM_SLAVES-1:0] present,
   input  wire logic [bus_program_pkg::NUM_SLAVES-1:0] diag_raise,
   input  wire logic                                   fail_set,
   input  wire logic                                   slow
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_r; // Cycles left before answering.
   logic       fail_r; // The next data answer reports a fault.

   // Answer after a short or long delay; a released line toggles so stale data is never seen.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         answer       <= '0;
         wait_r       <= 4'h0;
         fail_r       <= 1'b0;
         diag_changed <= '0;
      end
      else
      begin
         diag_changed <= diag_changed | diag_raise;
         if (fail_set)
            fail_r <= 1'b1;
         if (!request.valid)
         begin
            answer.valid <= 1'b0;
            answer.ok    <= ~answer.ok;
            answer.data  <= ~answer.data;
            wait_r       <= slow ? 4'h6 : 4'h1;
         end
         else if (wait_r != 4'h0)
            wait_r <= wait_r - 4'h1;
         else if (!answer.valid)
         begin
            answer.valid <= 1'b1;
            answer.data  <= 8'h50 | 8'(request.slave);
            case (request.kind)
               TG_PROBE: answer.ok <= present[request.slave];
               TG_DATA:
               begin
                  // A fault is reported once, then the station behaves again.
                  answer.ok <= present[request.slave] & ~fail_r;
                  fail_r    <= 1'b0;
               end
               default:
               begin
                  answer.ok                   <= 1'b1;
                  diag_changed[request.slave] <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule : slave_station_model
`default_nettype wire

// ==== verif/test_bus_program_seq.sv ====
`default_nettype none
// Directed bench for the bus program sequencer.
module test_bus_program_seq;
   timeunit 1ns;
   timeprecision 1ns;
   import bus_program_pkg::*;
   logic                  clk, rst_n, ce, multi_master, token_in, in_ready;
   logic                  slow, fail_set, token_out, in_valid, steady, prev_valid;
   logic [NUM_SLAVES-1:0] slave_cfg, out_data_flat_en, present, diag_raise;
   logic [NUM_SLAVES-1:0] diag_changed, slave_ok;
   logic [DATA_W-1:0]     out_data, in_data;
   answer_s               answer;
   request_s              request;
   int                    fail_count, check_count, tok_seen;
   telegram_e             kind_q[$];  // Kinds of requests seen, in order.
   logic [IDX_W-1:0]      slave_q[$]; // Slaves addressed, in order.
   logic [DATA_W-1:0]     word_q[$];  // Input words taken from the FIFO.

   bus_program_seq uut (.clk(clk), .rst_n(rst_n), .ce(ce), .multi_master(multi_master),
      .slave_cfg(slave_cfg), .out_data_flat_en(out_data_flat_en), .out_data(out_data),
      .token_in(token_in), .answer(answer), .diag_changed(diag_changed), .request(request),
      .token_out(token_out), .slave_ok(slave_ok), .in_valid(in_valid), .in_ready(in_ready),
      .in_data(in_data), .steady(steady));
   slave_station_model slaves (.clk(clk), .rst_n(rst_n), .request(request), .answer(answer),
      .diag_changed(diag_changed), .present(present), .diag_raise(diag_raise),
      .fail_set(fail_set), .slow(slow));

   // Free-running 100 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Monitor: log each new request, every word drained and every token pulse.
   always @(posedge clk)
   begin
      prev_valid <= request.valid;
      if (request.valid === 1'b1 && prev_valid !== 1'b1)
      begin
         kind_q.push_back(request.kind);
         slave_q.push_back(request.slave);
         if (request.kind == TG_DATA)
            check(request.data, out_data);
      end
      if (in_valid === 1'b1 && in_ready === 1'b1)
         word_q.push_back(in_data);
      if (token_out === 1'b1)
         tok_seen <= tok_seen + 1;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic results;
      if (fail_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results

   function automatic int count_of(input telegram_e k, input logic [IDX_W-1:0] s, input bit any);
      int c = 0;
      foreach (kind_q[i])
         if (kind_q[i] == k && (any || slave_q[i] == s))
            c++;
      return c;
   endfunction : count_of

   // Bounded wait for n requests of one kind; a hang ends the run as a failure.
   task automatic wait_for(input telegram_e k, input logic [IDX_W-1:0] s, input bit any,
                           input int n);
      int i;
      for (i = 0; i < 4000 && count_of(k, s, any) < n; i++)
         @(posedge clk);
      if (i == 4000)
      begin
         fail_count++;
         results();
      end
   endtask : wait_for

   task automatic clear_log;
      kind_q.delete();
      slave_q.delete();
      word_q.delete();
   endtask : clear_log

   task automatic expect_entry(input int i, input telegram_e k, input logic [IDX_W-1:0] s);
      check(kind_q[i], k);
      check(slave_q[i], s);
   endtask : expect_entry

   task automatic do_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      check(request.valid, 1'b0);
      check(slave_ok, 4'h0);
      rst_n <= 1'b1;
      clear_log();
   endtask : do_reset

   // Slave 2 absent: probe all, exchange with the others, then reprobe slave 2.
   task automatic power_up;
      wait_for(TG_PROBE, 2'h2, 1'b0, 2);
      for (int i = 0; i < 4; i++)
         expect_entry(i, TG_PROBE, IDX_W'(i));
      expect_entry(4, TG_DATA, 2'h0);
      expect_entry(5, TG_DATA, 2'h1);
      expect_entry(6, TG_DATA, 2'h3);
      expect_entry(7, TG_PROBE, 2'h2);
      check(slave_ok, 4'hB);
      check(steady, 1'b1);
      check(word_q[0], 8'h50);
      check(word_q[2], 8'h53);
   endtask : power_up

   // Slave 2 comes back, is reconnected, then the loop runs without probes.
   task automatic steady_loop;
      present <= 4'hF;
      clear_log();
      wait_for(TG_DATA, 2'h0, 1'b1, 8);
      check(slave_ok, 4'hF);
      check(count_of(TG_DATA, 2'h2, 1'b0) > 0, 1'b1);
      clear_log();
      wait_for(TG_DATA, 2'h0, 1'b1, 8);
      check(count_of(TG_PROBE, 2'h0, 1'b1), 0);
   endtask : steady_loop

   // One faulty data answer must bring back a connecting cycle.
   task automatic error_reconnect;
      @(posedge clk);
      fail_set <= 1'b1;
      @(posedge clk);
      fail_set <= 1'b0;
      clear_log();
      wait_for(TG_DATA, 2'h0, 1'b1, 7);
      check(count_of(TG_PROBE, 2'h0, 1'b1) > 0, 1'b1);
   endtask : error_reconnect

   // A changed report is fetched after the data cycle, and only once.
   task automatic diagnostics;
      slow <= 1'b1;
      clear_log();
      @(posedge clk);
      diag_raise <= 4'h8;
      @(posedge clk);
      diag_raise <= 4'h0;
      wait_for(TG_DIAG, 2'h3, 1'b0, 1);
      check(kind_q[kind_q.size() - 2], TG_DATA);
      check(count_of(TG_DIAG, 2'h0, 1'b1), 1);
      clear_log();
      wait_for(TG_DATA, 2'h0, 1'b1, 8);
      check(count_of(TG_DIAG, 2'h0, 1'b1), 0);
      slow <= 1'b0;
   endtask : diagnostics

   // Fill the input FIFO until the data cycle stalls, then drain it in order.
   task automatic fifo_fill;
      out_data_flat_en <= 4'h0;
      repeat (100) @(posedge clk);
      check(in_valid, 1'b0);
      in_ready         <= 1'b0;
      out_data_flat_en <= 4'hF;
      clear_log();
      repeat (600) @(posedge clk);
      check(count_of(TG_DATA, 2'h0, 1'b1), FIFO_DEPTH);
      in_ready <= 1'b1;
      repeat (60) @(posedge clk);
      // Each word must come from the slave of the matching data request.
      for (int i = 0; i < FIFO_DEPTH; i++)
         check(word_q[i], 8'h50 | 8'(slave_q[i]));
   endtask : fifo_fill

   // Several masters: silent without the token, one pass and one hand-off with it.
   task automatic token_pass;
      int i;
      multi_master <= 1'b1;
      do_reset();
      repeat (100) @(posedge clk);
      check(kind_q.size(), 0);
      token_in <= 1'b1;
      for (i = 0; i < 2000 && tok_seen == 0; i++)
         @(posedge clk);
      if (i == 2000)
      begin
         fail_count++;
         results();
      end
      check(count_of(TG_PROBE, 2'h0, 1'b1), 4);
      check(count_of(TG_DATA, 2'h0, 1'b1), 4);
      token_in <= 1'b0;
      clear_log();
      repeat (100) @(posedge clk);
      check(kind_q.size(), 0);
      check(tok_seen, 1);
   endtask : token_pass

   // Main sequence.
   initial
   begin
      rst_n            = 1'b0;
      ce               = 1'b1;
      multi_master     = 1'b0;
      token_in         = 1'b0;
      in_ready         = 1'b1;
      slow             = 1'b0;
      fail_set         = 1'b0;
      slave_cfg        = 4'hF;
      out_data_flat_en = 4'hF;
      present          = 4'hB;
      diag_raise       = 4'h0;
      out_data         = 8'hC3;
      prev_valid       = 1'b0;
      fail_count       = 0;
      check_count      = 0;
      tok_seen         = 0;
      do_reset();
      power_up();
      steady_loop();
      error_reconnect();
      diagnostics();
      fifo_fill();
      token_pass();
      results();
   end
endmodule : test_bus_program_seq
`default_nettype wire
